/* hdl/glc_map.vh */
// Register map, field codes and timing constants of the line control block
// Operation
// - Four lines chosen by an index; every line setting held per line.
// - Each line has a direction bit: input or output.
// - Each line has a polarity invert bit that flips its level.
// - Level readback of selected line returns 1 for high, 0 for low.
// - Read-only vector gives all line levels, line n in bit n.
// - Per-line deglitch and debounce filters, each with width in microseconds.
// - Deglitch accepts a new level only after it persisted the full width.
// - Debounce passes first edge at once, then blocks changes for the width.
// - Deglitch result feeds the debounce filter.
// - Output source drives the line only while direction is output.
// - Sources: other line, soft output, counter, table block, exposure.
// - Sources also include frame-trigger-ready.
// - Soft output index picks a bit; writing the level sets that bit.
// - Soft output vector writes and reads all soft outputs, bit n each.
// - Read-only circuit type per line: tri-state, opto-coupled or open-drain.
// - Aux supply enable exists only on supporting lines and switches supply.
// - Table input trigger type: low, high, falling, rising or any edge.
// - Writing table bits all loads all eight bits of selected table.
// - Row select chooses which table row the row bit reaches.
// - Row bit reads or writes the table entry at the selected row.
// - Each table has three inputs and eight configuration bits.
// - Block flip-flop loads value table result only while enable table true.
`ifndef GLC_MAP_VH
`define GLC_MAP_VH
`define GLC_OFF_LINE_SEL 8'h00
`define GLC_OFF_LINE_CFG 8'h04
`define GLC_OFF_FILT_SEL 8'h08
`define GLC_OFF_FILT_US 8'h0c
`define GLC_OFF_LEVEL 8'h10
`define GLC_OFF_LEVEL_ALL 8'h14
`define GLC_OFF_SOFT_IDX 8'h18
`define GLC_OFF_SOFT_LVL 8'h1c
`define GLC_OFF_SOFT_ALL 8'h20
`define GLC_OFF_TBL_SEL 8'h24
`define GLC_OFF_TBL_ALL 8'h28
`define GLC_OFF_TBL_ROW 8'h2c
`define GLC_OFF_TBL_BIT 8'h30
`define GLC_OFF_TBL_IN_SEL 8'h34
`define GLC_OFF_TBL_TRIG 8'h38
// Line config fields
`define GLC_CFG_DIR 0
`define GLC_CFG_INV 1
`define GLC_CFG_AUX 2
`define GLC_CFG_SRC_LO 4
`define GLC_CFG_SRC_HI 7
`define GLC_CFG_TYPE_LO 8
`define GLC_CFG_TYPE_HI 9
// Output sources
`define GLC_SRC_LINE0 4'h0
`define GLC_SRC_SOFT0 4'h4
`define GLC_SRC_COUNTER 4'h8
`define GLC_SRC_BLOCK 4'h9
`define GLC_SRC_EXPOSE 4'ha
`define GLC_SRC_FTRIG 4'hb
// Circuit types
`define GLC_TYPE_TRI 2'h0
`define GLC_TYPE_OPTO 2'h1
`define GLC_TYPE_OD 2'h2
// Trigger types
`define GLC_TRIG_LOW 3'h0
`define GLC_TRIG_HIGH 3'h1
`define GLC_TRIG_FALL 3'h2
`define GLC_TRIG_RISE 3'h3
`define GLC_TRIG_ANY 3'h4
// Reset values
`define GLC_TBL_RESET 8'h00
`define GLC_US_RESET 16'h0000
// Timing
`define GLC_CLK_MHZ 125
`define GLC_CNT_W 24
`endif

/* hdl/glc_line_control.v */
// Four-line I/O control with filters, output muxing and a table logic block
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "glc_map.vh"
module glc_line_control (
    input wire CLK_I,
    input wire RESETN_I,
    input wire [7:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    output reg [31:0] AVS_READDATA_O,
    output reg AVS_WAITREQUEST_O,
    input wire [3:0] LINE_I,
    output reg [3:0] LINE_O,
    output reg [3:0] LINE_OE_O,
    output reg [3:0] AUX_SUPPLY_EN_O,
    input wire COUNTER_ACTIVE_I,
    input wire EXPOSURE_ACTIVE_I,
    input wire FRAME_TRIGGER_READY_I,
    input wire [3:0] TBL_SRC_I,
    output reg BLOCK_OUT_O
);
    // Circuit type per line; fixed by the board
    parameter [7:0] LINE_TYPES = {`GLC_TYPE_TRI, `GLC_TYPE_TRI, `GLC_TYPE_OD, `GLC_TYPE_OPTO};
    parameter [3:0] AUX_CAPABLE = 4'h4;

    reg [1:0] line_index_select_r;
    reg [3:0] line_direction_r;
    reg [3:0] line_polarity_invert_r;
    reg [3:0] aux_supply_enable_r;
    reg [15:0] output_signal_select_r;
    reg input_filter_kind_select_r;
    reg [15:0] deglitch_us_r [0:3];
    reg [15:0] debounce_us_r [0:3];
    reg [1:0] soft_output_index_r;
    reg [3:0] soft_output_vector_r;
    reg table_kind_select_r;
    reg [7:0] value_tbl_r;
    reg [7:0] enable_tbl_r;
    reg [2:0] table_row_select_r;
    reg [1:0] tbl_in_sel_r;
    reg [8:0] table_input_trigger_type_r;
    reg [3:0] sync1_r;
    reg [3:0] sync2_r;
    wire [3:0] glitch_out;
    wire [3:0] bounce_out;
    reg [2:0] tbl_in_d_r;
    reg block_q_r;
    reg [3:0] line_level;
    reg [31:0] rd_nxt;
    reg [3:0] drive_nxt;

    // Trigger evaluation of one table input
    function trig_eval;
        input [2:0] kind;
        input cur;
        input prev;
        begin
            case (kind)
                `GLC_TRIG_LOW: trig_eval = ~cur;
                `GLC_TRIG_HIGH: trig_eval = cur;
                `GLC_TRIG_FALL: trig_eval = prev & ~cur;
                `GLC_TRIG_RISE: trig_eval = ~prev & cur;
                `GLC_TRIG_ANY: trig_eval = prev ^ cur;
                default: trig_eval = 1'b0;
            endcase
        end
    endfunction

    // Microseconds to clock cycles
    function [`GLC_CNT_W-1:0] us_cycles;
        input [15:0] us;
        reg [31:0] prod;
        begin
            prod = {16'h0000, us} * `GLC_CLK_MHZ;
            // Largest width still fits the counter
            us_cycles = prod[`GLC_CNT_W-1:0];
        end
    endfunction

    wire wr = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
    wire rd = AVS_READ_I & ~AVS_WAITREQUEST_O;
    wire [1:0] ls = line_index_select_r;

    // Table inputs and flip-flop
    wire [2:0] tbl_act;
    genvar t;
    generate
        for (t = 0; t < 3; t = t + 1) begin : g_tin
            assign tbl_act[t] = trig_eval(table_input_trigger_type_r[3*t+2:3*t],
                                          TBL_SRC_I[t], tbl_in_d_r[t]);
        end
    endgenerate
    wire value_res = value_tbl_r[tbl_act];
    wire enable_res = enable_tbl_r[tbl_act];

    // Per-line input filtering
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_line
            reg [`GLC_CNT_W-1:0] gcnt_r;
            reg [`GLC_CNT_W-1:0] bcnt_r;
            reg glitch_r;
            reg bounce_r;
            // One driver per line keeps the vectors single-sourced
            assign glitch_out[g] = glitch_r;
            assign bounce_out[g] = bounce_r;
            always @(posedge CLK_I) begin
                if (!RESETN_I) begin
                    gcnt_r <= {`GLC_CNT_W{1'b0}};
                    bcnt_r <= {`GLC_CNT_W{1'b0}};
                    glitch_r <= 1'b0;
                    bounce_r <= 1'b0;
                end else begin
                    // Deglitch: count while raw differs from accepted level
                    if (sync2_r[g] == glitch_r) begin
                        gcnt_r <= {`GLC_CNT_W{1'b0}};
                    end else if (gcnt_r + 1'b1 >= us_cycles(deglitch_us_r[g])) begin
                        glitch_r <= sync2_r[g];
                        gcnt_r <= {`GLC_CNT_W{1'b0}};
                    end else begin
                        gcnt_r <= gcnt_r + 1'b1;
                    end
                    // Debounce: pass edge, then hold off
                    if (bcnt_r != {`GLC_CNT_W{1'b0}}) begin
                        bcnt_r <= bcnt_r - 1'b1;
                    end else if (glitch_r != bounce_r) begin
                        bounce_r <= glitch_r;
                        bcnt_r <= us_cycles(debounce_us_r[g]);
                    end
                end
            end
        end
    endgenerate

    // Line level after the inverter; outputs reflect driven value
    always @* begin
        line_level = (line_direction_r & LINE_O) |
                     (~line_direction_r & (bounce_out ^ line_polarity_invert_r));
    end

    // Output source multiplexer
    integer k;
    always @* begin
        drive_nxt = 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            case (output_signal_select_r[4*k+:4])
                4'h0, 4'h1, 4'h2, 4'h3:
                    drive_nxt[k] = line_level[output_signal_select_r[4*k+:2]];
                4'h4, 4'h5, 4'h6, 4'h7:
                    drive_nxt[k] = soft_output_vector_r[output_signal_select_r[4*k+:2]];
                `GLC_SRC_COUNTER: drive_nxt[k] = COUNTER_ACTIVE_I;
                `GLC_SRC_BLOCK: drive_nxt[k] = block_q_r;
                `GLC_SRC_EXPOSE: drive_nxt[k] = EXPOSURE_ACTIVE_I;
                `GLC_SRC_FTRIG: drive_nxt[k] = FRAME_TRIGGER_READY_I;
                default: drive_nxt[k] = 1'b0;
            endcase
        end
        drive_nxt = drive_nxt ^ line_polarity_invert_r;
    end

    // Read mux
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (AVS_ADDRESS_I)
            `GLC_OFF_LINE_SEL: rd_nxt[1:0] = ls;
            `GLC_OFF_LINE_CFG: begin
                rd_nxt[`GLC_CFG_DIR] = line_direction_r[ls];
                rd_nxt[`GLC_CFG_INV] = line_polarity_invert_r[ls];
                rd_nxt[`GLC_CFG_AUX] = aux_supply_enable_r[ls];
                rd_nxt[`GLC_CFG_SRC_HI:`GLC_CFG_SRC_LO] = output_signal_select_r[4*ls+:4];
                rd_nxt[`GLC_CFG_TYPE_HI:`GLC_CFG_TYPE_LO] = LINE_TYPES[2*ls+:2];
            end
            `GLC_OFF_FILT_SEL: rd_nxt[0] = input_filter_kind_select_r;
            `GLC_OFF_FILT_US: rd_nxt[15:0] = input_filter_kind_select_r ?
                                              debounce_us_r[ls] : deglitch_us_r[ls];
            `GLC_OFF_LEVEL: rd_nxt[0] = line_level[ls];
            `GLC_OFF_LEVEL_ALL: rd_nxt[3:0] = line_level;
            `GLC_OFF_SOFT_IDX: rd_nxt[1:0] = soft_output_index_r;
            `GLC_OFF_SOFT_LVL: rd_nxt[0] = soft_output_vector_r[soft_output_index_r];
            `GLC_OFF_SOFT_ALL: rd_nxt[3:0] = soft_output_vector_r;
            `GLC_OFF_TBL_SEL: rd_nxt[0] = table_kind_select_r;
            `GLC_OFF_TBL_ALL: rd_nxt[7:0] = table_kind_select_r ? enable_tbl_r : value_tbl_r;
            `GLC_OFF_TBL_ROW: rd_nxt[2:0] = table_row_select_r;
            `GLC_OFF_TBL_BIT: rd_nxt[0] = table_kind_select_r ?
                                           enable_tbl_r[table_row_select_r] :
                                           value_tbl_r[table_row_select_r];
            `GLC_OFF_TBL_IN_SEL: rd_nxt[1:0] = tbl_in_sel_r;
            `GLC_OFF_TBL_TRIG: rd_nxt[2:0] = (tbl_in_sel_r == 2'h3) ? 3'h0 :
                                              table_input_trigger_type_r[3*tbl_in_sel_r+:3];
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Registers and bus
    always @(posedge CLK_I) begin
        if (!RESETN_I) begin
            AVS_READDATA_O <= 32'h0000_0000;
            AVS_WAITREQUEST_O <= 1'b1;
            LINE_O <= 4'h0;
            LINE_OE_O <= 4'h0;
            AUX_SUPPLY_EN_O <= 4'h0;
            BLOCK_OUT_O <= 1'b0;
            line_index_select_r <= 2'h0;
            line_direction_r <= 4'h0;
            line_polarity_invert_r <= 4'h0;
            aux_supply_enable_r <= 4'h0;
            output_signal_select_r <= 16'h0000;
            input_filter_kind_select_r <= 1'b0;
            deglitch_us_r[0] <= `GLC_US_RESET;
            deglitch_us_r[1] <= `GLC_US_RESET;
            deglitch_us_r[2] <= `GLC_US_RESET;
            deglitch_us_r[3] <= `GLC_US_RESET;
            debounce_us_r[0] <= `GLC_US_RESET;
            debounce_us_r[1] <= `GLC_US_RESET;
            debounce_us_r[2] <= `GLC_US_RESET;
            debounce_us_r[3] <= `GLC_US_RESET;
            soft_output_index_r <= 2'h0;
            soft_output_vector_r <= 4'h0;
            table_kind_select_r <= 1'b0;
            value_tbl_r <= `GLC_TBL_RESET;
            enable_tbl_r <= `GLC_TBL_RESET;
            table_row_select_r <= 3'h0;
            tbl_in_sel_r <= 2'h0;
            table_input_trigger_type_r <= 9'h000;
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            tbl_in_d_r <= 3'h0;
            block_q_r <= 1'b0;
        end else begin
            sync1_r <= LINE_I;
            sync2_r <= sync1_r;
            tbl_in_d_r <= TBL_SRC_I[2:0];
            if (enable_res) begin
                block_q_r <= value_res;
            end
            BLOCK_OUT_O <= block_q_r;
            LINE_OE_O <= line_direction_r;
            LINE_O <= drive_nxt & line_direction_r;
            AUX_SUPPLY_EN_O <= aux_supply_enable_r & AUX_CAPABLE;
            // One wait cycle per access, then answer
            AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O);
            if (rd) begin
                AVS_READDATA_O <= 32'h0000_0000;
            end else begin
                AVS_READDATA_O <= rd_nxt;
            end
            if (wr) begin
                case (AVS_ADDRESS_I)
                    `GLC_OFF_LINE_SEL: line_index_select_r <= AVS_WRITEDATA_I[1:0];
                    `GLC_OFF_LINE_CFG: begin
                        line_direction_r[ls] <= AVS_WRITEDATA_I[`GLC_CFG_DIR];
                        line_polarity_invert_r[ls] <= AVS_WRITEDATA_I[`GLC_CFG_INV];
                        aux_supply_enable_r[ls] <= AVS_WRITEDATA_I[`GLC_CFG_AUX] &
                                                   AUX_CAPABLE[ls];
                        output_signal_select_r[4*ls+:4] <=
                            AVS_WRITEDATA_I[`GLC_CFG_SRC_HI:`GLC_CFG_SRC_LO];
                    end
                    `GLC_OFF_FILT_SEL: input_filter_kind_select_r <= AVS_WRITEDATA_I[0];
                    `GLC_OFF_FILT_US: begin
                        if (input_filter_kind_select_r) begin
                            debounce_us_r[ls] <= AVS_WRITEDATA_I[15:0];
                        end else begin
                            deglitch_us_r[ls] <= AVS_WRITEDATA_I[15:0];
                        end
                    end
                    `GLC_OFF_SOFT_IDX: soft_output_index_r <= AVS_WRITEDATA_I[1:0];
                    `GLC_OFF_SOFT_LVL:
                        soft_output_vector_r[soft_output_index_r] <= AVS_WRITEDATA_I[0];
                    `GLC_OFF_SOFT_ALL: soft_output_vector_r <= AVS_WRITEDATA_I[3:0];
                    `GLC_OFF_TBL_SEL: table_kind_select_r <= AVS_WRITEDATA_I[0];
                    `GLC_OFF_TBL_ALL: begin
                        if (table_kind_select_r) begin
                            enable_tbl_r <= AVS_WRITEDATA_I[7:0];
                        end else begin
                            value_tbl_r <= AVS_WRITEDATA_I[7:0];
                        end
                    end
                    `GLC_OFF_TBL_ROW: table_row_select_r <= AVS_WRITEDATA_I[2:0];
                    `GLC_OFF_TBL_BIT: begin
                        if (table_kind_select_r) begin
                            enable_tbl_r[table_row_select_r] <= AVS_WRITEDATA_I[0];
                        end else begin
                            value_tbl_r[table_row_select_r] <= AVS_WRITEDATA_I[0];
                        end
                    end
                    `GLC_OFF_TBL_IN_SEL: tbl_in_sel_r <= AVS_WRITEDATA_I[1:0];
                    `GLC_OFF_TBL_TRIG: begin
                        // Input3 has no table column; its setting is dropped
                        if (tbl_in_sel_r != 2'h3) begin
                            table_input_trigger_type_r[3*tbl_in_sel_r+:3] <=
                                AVS_WRITEDATA_I[2:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* sim/glc_line_monitor.sv */
// Port checker for the line control block
`timescale 1ns/1ps
`default_nettype none
`include "glc_map.vh"
module glc_line_monitor #(
    parameter logic [3:0] AUX_CAPABLE = 4'h4
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic [3:0] LINE_O,
    input wire logic [3:0] LINE_OE_O,
    input wire logic [3:0] AUX_SUPPLY_EN_O,
    input wire logic BLOCK_OUT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    wire req_w = AVS_READ_I || AVS_WRITE_I;
    wire rd_done = AVS_READ_I && !AVS_WAITREQUEST_O;
    wire cfg_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `GLC_OFF_LINE_CFG;
    answer_one_a: assert property (req_w && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("request not answered after one wait state");
    wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (!req_w |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low without a request");
    unmapped_zero_a: assert property (rd_done && AVS_ADDRESS_I > 8'h38 |-> AVS_READDATA_O == 0)
        else $error("unmapped read not zero");
    level_all_a: assert property (rd_done && AVS_ADDRESS_I == `GLC_OFF_LEVEL_ALL
        && $stable(LINE_O) && $stable(LINE_OE_O) |-> AVS_READDATA_O[31:4] == 0
        && ((AVS_READDATA_O[3:0] ^ LINE_O) & LINE_OE_O) == 4'h0)
        else $error("level vector disagrees with driven lines");
    soft_width_a: assert property (rd_done && AVS_ADDRESS_I == `GLC_OFF_SOFT_ALL
        |-> AVS_READDATA_O[31:4] == 0) else $error("soft vector has extra bits");
    oe_drive_a: assert property ((LINE_O & ~LINE_OE_O) == 4'h0)
        else $error("line driven while set as input");
    aux_only_a: assert property ((AUX_SUPPLY_EN_O & ~AUX_CAPABLE) == 4'h0)
        else $error("aux supply on a line without it");
    dir_by_write_a: assert property ($changed(LINE_OE_O) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("direction changed without a config write");
    aux_by_write_a: assert property ($changed(AUX_SUPPLY_EN_O) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("aux supply changed without a config write");
    cover property (cfg_wr);
    cover property (rd_done && AVS_ADDRESS_I == `GLC_OFF_LEVEL_ALL);
    cover property ($rose(BLOCK_OUT_O));
endmodule
bind glc_line_control glc_line_monitor #(.AUX_CAPABLE(AUX_CAPABLE)) mon (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LINE_O(LINE_O), .LINE_OE_O(LINE_OE_O),
    .AUX_SUPPLY_EN_O(AUX_SUPPLY_EN_O), .BLOCK_OUT_O(BLOCK_OUT_O));
`default_nettype wire

/* sim/glc_ext_circuit.sv */
// External circuits wired to the four connector lines
`timescale 1ns/1ps
`default_nettype none
module glc_ext_circuit (
    input wire logic [3:0] line_o_i,
    input wire logic [3:0] line_oe_i,
    input wire logic [3:0] stim_i,
    output logic [3:0] line_i_o
);
    // A driven pin reads back its own drive; an undriven one sees the outside level
    assign line_i_o = (line_oe_i & line_o_i) | (~line_oe_i & stim_i);
endmodule
`default_nettype wire

/* sim/glc_line_control_tb_top.sv */
// Self-checking bench for the line control block
`timescale 1ns/1ps
`default_nettype none
`include "glc_map.vh"
module glc_line_control_tb_top;
    localparam logic [7:0] TYPES = {`GLC_TYPE_TRI, `GLC_TYPE_TRI, `GLC_TYPE_OD, `GLC_TYPE_OPTO};
    localparam logic [3:0] AUXC = 4'h4;
    logic clk = 1'b0, resetn = 1'b0, rd_en = 1'b0, wr_en = 1'b0, wait_req, blk;
    logic cnt_act = 1'b0, exp_act = 1'b0, ftrig = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] ext = 4'h0, tsrc = 4'h0, line_in, line_out, line_oe, aux_en;
    int error_cnt = 0, n_compared = 0, cycles = 0;
    always #4 clk = ~clk;
    glc_line_control #(.LINE_TYPES(TYPES), .AUX_CAPABLE(AUXC)) dut (
        .CLK_I(clk), .RESETN_I(resetn), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
        .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wait_req), .LINE_I(line_in), .LINE_O(line_out),
        .LINE_OE_O(line_oe), .AUX_SUPPLY_EN_O(aux_en), .COUNTER_ACTIVE_I(cnt_act),
        .EXPOSURE_ACTIVE_I(exp_act), .FRAME_TRIGGER_READY_I(ftrig), .TBL_SRC_I(tsrc),
        .BLOCK_OUT_O(blk));
    glc_ext_circuit ext_ckt (.line_o_i(line_out), .line_oe_i(line_oe), .stim_i(ext),
        .line_i_o(line_in));
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        addr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= d;
        @(posedge clk);
        while (wait_req !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) check("waitrequest", 32'h0, 32'h1);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, exp, q);
    endtask
    task t_regs;
        for (int i = 0; i < 4; i++) begin
            wr(`GLC_OFF_LINE_SEL, i);
            wr(`GLC_OFF_LINE_CFG, 32'h304 | (i[0] << 1));
        end
        check("aux_pins", AUXC, aux_en);
        for (int i = 0; i < 4; i++) begin
            wr(`GLC_OFF_LINE_SEL, i);
            rd(`GLC_OFF_LINE_CFG, {22'h0, TYPES[2*i+:2], 5'h0, AUXC[i], i[0], 1'b0}, "cfg");
            wr(`GLC_OFF_LINE_CFG, 32'h0);
        end
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0, "unmapped");
        for (int j = 0; j < 3; j++) begin
            wr(`GLC_OFF_TBL_IN_SEL, j);
            for (int t = 0; t < 5; t++) begin
                wr(`GLC_OFF_TBL_TRIG, t);
                rd(`GLC_OFF_TBL_TRIG, t, "trigger_type");
            end
            // Level-high so each table input follows its source directly
            wr(`GLC_OFF_TBL_TRIG, `GLC_TRIG_HIGH);
        end
        $display("t_regs done");
    endtask
    task t_out;
        logic [7:0] v;
        ext <= 4'h9;
        wr(`GLC_OFF_SOFT_ALL, 32'ha);
        rd(`GLC_OFF_SOFT_ALL, 32'ha, "soft_vector");
        wr(`GLC_OFF_SOFT_IDX, 32'h0);
        wr(`GLC_OFF_SOFT_LVL, 32'h1);
        rd(`GLC_OFF_SOFT_ALL, 32'hb, "soft_vector");
        wr(`GLC_OFF_LINE_SEL, 32'h1);
        for (int p = 0; p < 2; p++) begin
            cnt_act <= !p[0];
            exp_act <= p[0];
            ftrig <= !p[0];
            v = {!p[0], p[0], 1'b0, !p[0], 4'hb};
            for (int s = 4; s < 12; s++) if (s != 9) begin
                wr(`GLC_OFF_LINE_CFG, {24'h0, s[3:0], 4'h1});
                repeat (2) @(posedge clk);
                check("line_drive", v[s-4], line_out[1]);
                rd(`GLC_OFF_LEVEL, v[s-4], "level");
            end
        end
        wr(`GLC_OFF_LINE_CFG, 32'h01);
        repeat (10) @(posedge clk);
        check("loop_back", 32'h1, line_out[1]);
        rd(`GLC_OFF_LEVEL_ALL, 32'hb, "level_all");
        wr(`GLC_OFF_LINE_CFG, 32'h40);
        repeat (2) @(posedge clk);
        check("line_oe", 32'h0, {line_oe[1], line_out[1]});
        $display("t_out done");
    endtask
    task t_in;
        wr(`GLC_OFF_LINE_SEL, 32'h0);
        wr(`GLC_OFF_FILT_SEL, 32'h0);
        wr(`GLC_OFF_FILT_US, 32'h1);
        ext[0] <= 1'b0;
        repeat (200) @(posedge clk);
        ext[0] <= 1'b1;
        repeat (100) @(posedge clk);
        ext[0] <= 1'b0;
        repeat (200) @(posedge clk);
        rd(`GLC_OFF_LEVEL, 32'h0, "glitch");
        ext[0] <= 1'b1;
        repeat (100) @(posedge clk);
        rd(`GLC_OFF_LEVEL, 32'h0, "deglitch_wait");
        repeat (40) @(posedge clk);
        rd(`GLC_OFF_LEVEL, 32'h1, "deglitch_pass");
        wr(`GLC_OFF_LINE_CFG, 32'h2);
        rd(`GLC_OFF_LEVEL, 32'h0, "inverted");
        wr(`GLC_OFF_LINE_CFG, 32'h0);
        wr(`GLC_OFF_FILT_US, 32'h0);
        wr(`GLC_OFF_FILT_SEL, 32'h1);
        wr(`GLC_OFF_FILT_US, 32'h2);
        ext[0] <= 1'b0;
        repeat (8) @(posedge clk);
        rd(`GLC_OFF_LEVEL, 32'h0, "first_edge");
        ext[0] <= 1'b1;
        repeat (30) @(posedge clk);
        rd(`GLC_OFF_LEVEL, 32'h0, "bounce_held");
        repeat (260) @(posedge clk);
        rd(`GLC_OFF_LEVEL, 32'h1, "bounce_over");
        $display("t_in done");
    endtask
    task t_tbl;
        wr(`GLC_OFF_TBL_SEL, 32'h0);
        wr(`GLC_OFF_TBL_ALL, 32'hc0);
        rd(`GLC_OFF_TBL_ALL, 32'hc0, "table_all");
        for (int r = 0; r < 8; r++) begin
            wr(`GLC_OFF_TBL_ROW, r);
            rd(`GLC_OFF_TBL_BIT, r > 5, "row_bit");
        end
        wr(`GLC_OFF_TBL_ROW, 32'h1);
        wr(`GLC_OFF_TBL_BIT, 32'h1);
        rd(`GLC_OFF_TBL_ALL, 32'hc2, "table_all");
        wr(`GLC_OFF_TBL_SEL, 32'h1);
        wr(`GLC_OFF_TBL_ALL, 32'hff);
        for (int s = 0; s < 8; s++) begin
            tsrc <= s[3:0];
            repeat (8) @(posedge clk);
            check("block_out", (32'hc2 >> s) & 1, blk);
        end
        wr(`GLC_OFF_TBL_ALL, 32'h0);
        tsrc <= 4'h0;
        repeat (8) @(posedge clk);
        check("block_hold", 32'h1, blk);
        wr(`GLC_OFF_LINE_CFG, 32'h91);
        repeat (2) @(posedge clk);
        check("block_drive", 32'h1, line_out[0]);
        wr(`GLC_OFF_TBL_SEL, 32'h0);
        rd(`GLC_OFF_TBL_ALL, 32'hc2, "value_table");
        // Rising edge on input 0 gives a one-cycle pass through row 1
        wr(`GLC_OFF_TBL_SEL, 32'h1);
        wr(`GLC_OFF_TBL_ALL, 32'hff);
        wr(`GLC_OFF_TBL_IN_SEL, 32'h0);
        wr(`GLC_OFF_TBL_TRIG, `GLC_TRIG_RISE);
        tsrc <= 4'h1;
        repeat (3) @(posedge clk);
        check("rise_pulse", 32'h1, blk);
        @(posedge clk);
        check("rise_end", 32'h0, blk);
        $display("t_tbl done");
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            final_report;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_out;
        t_in;
        t_tbl;
        final_report;
    end
endmodule
`default_nettype wire
